// [rtl/plt_loopback.sv]
// Device-side loopback path and PHY test-mode control.
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

module plt_loopback
  import plt_pkg::*;
(
  input  wire logic        clk_in,                 // System clock, 100 MHz
  input  wire logic        rst_n_in,               // Synchronous reset, active low
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,         // Byte address
  input  wire logic        avs_read_in,            // Read request
  input  wire logic        avs_write_in,           // Write request
  input  wire logic [31:0] avs_writedata_in,       // Write data
  input  wire logic [3:0]  avs_byteenable_in,      // Byte lanes
  output logic      [31:0] avs_readdata_out,       // Read data, registered
  output logic             avs_waitrequest_out,    // Stall until answer
  // Recovered link side, outside the clock domain
  input  wire logic        sym_clk_in,             // Recovered symbol clock
  input  wire logic [9:0]  h2d_rx_sym_in,          // Deserializer out, host_to_device_lane
  input  wire logic [7:0]  h2d_rx_byte_in,         // Decoded byte, host_to_device_lane
  input  wire logic        h2d_rx_k_in,            // Control code flag
  input  wire logic [9:0]  d2h_rx_sym_in,          // Deserializer out, device_to_host_lane
  input  wire logic [7:0]  d2h_rx_byte_in,         // Decoded byte, device_to_host_lane
  input  wire logic        d2h_rx_k_in,            // Control code flag
  input  wire logic        amp_det_in,             // Amplitude detector wake flag
  // Link layer side, same clock
  input  wire logic [9:0]  h2d_tx_link_sym_in,     // Link symbol for host_to_device_lane
  input  wire logic [9:0]  d2h_tx_link_sym_in,     // Link symbol for device_to_host_lane
  input  wire logic        ll_loop_en_in,          // Link layer loopback enable
  input  wire logic        ll_loop_back_in,        // Link layer direction, 1 backward
  input  wire logic        lp_req_in,              // Request to enter low power
  // Serializer and PHY control
  output logic      [9:0]  h2d_tx_sym_out,         // Serializer in, host_to_device_lane
  output logic      [9:0]  d2h_tx_sym_out,         // Serializer in, device_to_host_lane
  output logic             h2d_tx_oe_out,          // Drive host_to_device_lane
  output logic             d2h_tx_oe_out,          // Drive device_to_host_lane
  output logic             phy_power_en_out,       // PHY circuitry powered
  output logic             amp_det_en_out,         // Amplitude detector powered
  output logic             pll_run_out,            // PLL running
  output logic      [2:0]  pll_mult_out,           // Active multiplier code
  output logic             cdr_resync_out,         // One-cycle CDR resync pulse
  output logic             test_mode_out           // PHY test mode active
);

  // Decoded sync symbol; arbitrary value, set by integration
  parameter logic [7:0] SYNC_SYM_BYTE = 8'h00;
  parameter logic       SYNC_SYM_IS_K = 1'b1;

  localparam int RAW_W = 40;                        // Width of synchronised bundle

  logic [RAW_W-1:0] raw;                            // Asynchronous inputs bundled
  logic [RAW_W-1:0] meta;                           // First synchroniser stage
  logic [RAW_W-1:0] sync;                           // Second stage, safe to read
  logic             clk_prev;                       // Last synced symbol clock
  logic             sym_stb;                        // Symbol clock rising edge
  logic [1:0][9:0]  rx_sym;                         // Synced symbol per lane
  logic [1:0][7:0]  rx_byte;                        // Synced byte per lane
  logic [1:0]       rx_k;                           // Synced K flag per lane
  logic [1:0][9:0]  cap_sym;                        // Captured symbol per lane
  logic             amp_sync;                       // Synced detector flag
  logic [1:0]       rx_sync_hit;                    // Sync symbol seen per lane
  logic [1:0]       entry_hit;                      // Four entry symbols per lane
  logic [1:0][7:0]  entry_p;                        // Primary per lane
  logic [1:0][7:0]  entry_s;                        // Secondary per lane
  logic             hit;                            // Accepted entry
  logic [7:0]       hit_p;                          // Accepted primary
  logic [7:0]       hit_s;                          // Accepted secondary
  plt_pstate_t      pstate;                         // Power state
  plt_pstate_t      next_pstate;                    // Next power state
  logic             test_active;                    // In PHY test mode
  logic             disc;                           // Disconnect mode held
  logic             pend_valid;                     // Deferred sub mode waiting
  logic             pend_disc;                      // Deferred disconnect choice
  logic [2:0]       pend_mult;                      // Multiplier for next exit
  logic             test_dir;                       // Test direction, 1 backward
  logic [7:0]       cur_p;                          // Last accepted primary
  logic [7:0]       cur_s;                          // Last accepted secondary
  logic             dir_eff;                        // Direction in force
  logic             loop_eff;                       // Loopback in force
  logic             dir_q;                          // Direction last cycle
  logic             switching;                      // Both lanes floated
  logic             resync_pref;                    // Control: prefer Re-Sync
  logic             bus_ack;                        // Answer cycle of access

  // Bundle every input from outside the domain for one synchroniser
  assign raw = {amp_det_in, sym_clk_in,
                d2h_rx_k_in, d2h_rx_byte_in, d2h_rx_sym_in,
                h2d_rx_k_in, h2d_rx_byte_in, h2d_rx_sym_in};

  // Two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= raw;
      sync <= meta;
    end
  end

  // Unpack synced bundle; data and clock share latency, so data is
  // taken at the symbol clock's rising edge while it is stable
  assign rx_sym[PLT_LANE_H2D]  = sync[9:0];
  assign rx_byte[PLT_LANE_H2D] = sync[17:10];
  assign rx_k[PLT_LANE_H2D]    = sync[18];
  assign rx_sym[PLT_LANE_D2H]  = sync[28:19];
  assign rx_byte[PLT_LANE_D2H] = sync[36:29];
  assign rx_k[PLT_LANE_D2H]    = sync[37];
  assign amp_sync              = sync[39];
  assign sym_stb               = sync[38] & ~clk_prev;

  // Edge finder for the symbol clock
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= sync[38];
    end
  end

  // Per-lane capture and entry-symbol recogniser
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      logic [1:0] pos;                              // Byte slot inside entry symbol
      logic [2:0] cnt;                              // Identical instances so far
      logic [7:0] p_new;                            // Primary of current instance
      logic [7:0] last_p;                           // Primary of previous instance
      logic [7:0] last_s;                           // Secondary of previous instance
      logic       hit_q;                            // Recognition pulse

      // Raw 10-bit capture, no decoding so illegal codes pass too
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          cap_sym[g] <= PLT_SYM_RESET;
        end else if (sym_stb) begin
          cap_sym[g] <= rx_sym[g];
        end
      end

      assign rx_sync_hit[g] = sym_stb && (rx_byte[g] == SYNC_SYM_BYTE)
                              && (rx_k[g] == SYNC_SYM_IS_K);

      // Comma, K30.7, primary, secondary; any break restarts the count
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          pos    <= 2'd0;
          cnt    <= 3'd0;
          p_new  <= PLT_SETTING_RESET;
          last_p <= PLT_SETTING_RESET;
          last_s <= PLT_SETTING_RESET;
          hit_q  <= 1'b0;
        end else begin
          hit_q <= 1'b0;
          if (sym_stb) begin
            case (pos)
              2'd0: begin
                // Comma opens an instance
                if (rx_k[g] && rx_byte[g] == PLT_COMMA_BYTE) begin
                  pos <= 2'd1;
                end else begin
                  cnt <= 3'd0;
                end
              end
              2'd1: begin
                // Control code follows the comma
                if (rx_k[g] && rx_byte[g] == PLT_ENTRY_KCODE) begin
                  pos <= 2'd2;
                end else begin
                  pos <= 2'd0;
                  cnt <= 3'd0;
                end
              end
              2'd2: begin
                // Primary setting byte
                if (!rx_k[g]) begin
                  p_new <= rx_byte[g];
                  pos   <= 2'd3;
                end else begin
                  pos <= 2'd0;
                  cnt <= 3'd0;
                end
              end
              default: begin
                // Secondary byte closes an instance; count identical repeats
                pos <= 2'd0;
                if (rx_k[g]) begin
                  cnt <= 3'd0;
                end else begin
                  last_p <= p_new;
                  last_s <= rx_byte[g];
                  if (cnt != 3'd0 && (p_new != last_p || rx_byte[g] != last_s)) begin
                    cnt <= 3'd1;
                  end else if (cnt == PLT_ENTRY_REPEAT - 3'd1) begin
                    cnt   <= 3'd0;
                    hit_q <= 1'b1;
                  end else begin
                    cnt <= cnt + 3'd1;
                  end
                end
              end
            endcase
          end
        end
      end

      assign entry_hit[g] = hit_q;
      assign entry_p[g]   = last_p;
      assign entry_s[g]   = last_s;
    end
  endgenerate

  // Only the lane that the test direction listens on is heard:
  // forward listens on host_to_device, backward on device_to_host
  assign hit   = test_dir ? entry_hit[PLT_LANE_D2H]
                          : entry_hit[PLT_LANE_H2D];
  assign hit_p = test_dir ? entry_p[PLT_LANE_D2H] : entry_p[PLT_LANE_H2D];
  assign hit_s = test_dir ? entry_s[PLT_LANE_D2H] : entry_s[PLT_LANE_H2D];

  // Test settings; they survive Dormant and Re-Sync until replaced
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      test_active <= 1'b0;
      disc        <= 1'b0;
      pend_valid  <= 1'b0;
      pend_disc   <= 1'b0;
      pend_mult   <= PLT_MULT_X15;
      pll_mult_out <= PLT_MULT_X15;
      test_dir    <= 1'b0;
      cur_p       <= PLT_SETTING_RESET;
      cur_s       <= PLT_SETTING_RESET;
    end else begin
      if (pstate == PLT_PS_EXIT) begin
        // Deferred choices land on the common exit
        pll_mult_out <= pend_mult;
        if (pend_valid) begin
          disc       <= pend_disc;
          pend_valid <= 1'b0;
        end
      end
      if (hit) begin
        cur_p       <= hit_p;
        cur_s       <= hit_s;
        test_active <= 1'b1;
        if (hit_p[7:4] == PLT_MAIN_LOOPBACK) begin
          test_dir <= hit_s[PLT_SEC_DIR_BIT];
          // Reserved multiplier codes leave the pending value alone
          if (hit_s[PLT_SEC_MULT_MSB:0] == PLT_MULT_X15 ||
              hit_s[PLT_SEC_MULT_MSB:0] == PLT_MULT_X30) begin
            pend_mult <= hit_s[PLT_SEC_MULT_MSB:0];
          end
          if (!hit_p[PLT_SUB_TIMING_BIT]) begin
            disc       <= hit_p[PLT_SUB_DISC_BIT];
            pend_valid <= 1'b0;
          end else begin
            pend_disc  <= hit_p[PLT_SUB_DISC_BIT];
            pend_valid <= 1'b1;
          end
        end
        // Vendor main mode is recorded only; no standard action taken
      end
    end
  end

  // Test mode owns the mux; otherwise the link layer does
  assign loop_eff = (test_active && cur_p[7:4] == PLT_MAIN_LOOPBACK)
                    || (!test_active && ll_loop_en_in);
  assign dir_eff  = test_active ? test_dir : ll_loop_back_in;

  // Direction change floats both lanes until sync arrives on new receiver;
  // symbols sent around the switch may be broken, which is tolerated
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dir_q     <= 1'b0;
      switching <= 1'b0;
    end else begin
      dir_q <= dir_eff;
      if (dir_eff != dir_q) begin
        switching <= 1'b1;
      end else if (switching && rx_sync_hit[dir_eff ? PLT_LANE_D2H : PLT_LANE_H2D]) begin
        switching <= 1'b0;
      end
    end
  end

  // Serializer inputs: loop symbol into the other lane or link data
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      h2d_tx_sym_out <= PLT_SYM_RESET;
      d2h_tx_sym_out <= PLT_SYM_RESET;
    end else begin
      if (loop_eff && dir_eff) begin
        h2d_tx_sym_out <= cap_sym[PLT_LANE_D2H];
      end else begin
        h2d_tx_sym_out <= h2d_tx_link_sym_in;
      end
      if (loop_eff && !dir_eff) begin
        d2h_tx_sym_out <= cap_sym[PLT_LANE_H2D];
      end else begin
        d2h_tx_sym_out <= d2h_tx_link_sym_in;
      end
    end
  end

  // Power state register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pstate <= PLT_PS_ACTIVE;
    end else begin
      pstate <= next_pstate;
    end
  end

  // Power state transitions
  always_comb begin
    next_pstate = pstate;
    case (pstate)
      PLT_PS_ACTIVE: begin
        if (lp_req_in) begin
          // Forward loopback never uses Re-Sync; it uses Dormant unless disconnect mode is held
          if (resync_pref && dir_eff) begin
            next_pstate = PLT_PS_RESYNC;
          end else if (!(test_active && disc)) begin
            next_pstate = PLT_PS_DORMANT;
          end
        end
      end
      PLT_PS_DORMANT: begin
        if (amp_sync) begin
          next_pstate = PLT_PS_EXIT;
        end
      end
      PLT_PS_RESYNC: begin
        if (|rx_sync_hit) begin
          next_pstate = PLT_PS_EXIT;
        end
      end
      PLT_PS_EXIT: begin
        next_pstate = PLT_PS_ACTIVE;
      end
      default: begin
        next_pstate = PLT_PS_ACTIVE;
      end
    endcase
  end

  // Power controls; detector stays up, PLL stops only while needed
  assign phy_power_en_out = (pstate != PLT_PS_DORMANT);
  assign amp_det_en_out   = 1'b1;
  assign pll_run_out      = (pstate == PLT_PS_ACTIVE) || (pstate == PLT_PS_EXIT)
                            || (pstate == PLT_PS_RESYNC && pend_mult == pll_mult_out);
  assign cdr_resync_out   = (pstate == PLT_PS_EXIT);
  assign test_mode_out    = test_active;

  // Lane drivers: only the transmit lane of the direction, never in
  // Dormant and never while a direction switch is pending; the cycle in
  // which the direction flips floats both too, before switching is set
  assign h2d_tx_oe_out = dir_eff && (dir_eff == dir_q) && !switching
                         && phy_power_en_out;
  assign d2h_tx_oe_out = !dir_eff && (dir_eff == dir_q) && !switching
                         && phy_power_en_out;

  // Avalon answer comes one cycle after the request is seen
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !bus_ack;

  // Bus acknowledge and control register write
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus_ack     <= 1'b0;
      resync_pref <= PLT_CTRL_RESET;
    end else begin
      bus_ack <= (avs_read_in || avs_write_in) && !bus_ack;
      // Write lands on the answer edge, where the master sees waitrequest low
      if (avs_write_in && bus_ack && avs_address_in == PLT_OFS_CTRL
          && avs_byteenable_in[0]) begin
        resync_pref <= avs_writedata_in[PLT_CTRL_RESYNC_BIT];
      end
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !bus_ack) begin
      avs_readdata_out <= 32'h0000_0000;
      case (avs_address_in)
        PLT_OFS_CTRL: begin
          avs_readdata_out[PLT_CTRL_RESYNC_BIT] <= resync_pref;
        end
        PLT_OFS_STATUS: begin
          avs_readdata_out[PLT_ST_TEST_BIT]   <= test_active;
          avs_readdata_out[PLT_ST_DISC_BIT]   <= disc;
          avs_readdata_out[PLT_ST_DIR_BIT]    <= dir_eff;
          avs_readdata_out[PLT_ST_SWITCH_BIT] <= switching;
          avs_readdata_out[PLT_ST_OE_LSB+:2]  <= {d2h_tx_oe_out, h2d_tx_oe_out};
          avs_readdata_out[PLT_ST_MULT_LSB+:3] <= pll_mult_out;
          avs_readdata_out[PLT_ST_STATE_LSB+:4] <= pstate;
        end
        PLT_OFS_SETTING: begin
          avs_readdata_out[15:0] <= {cur_s, cur_p};
        end
        default: begin
          avs_readdata_out <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [rtl/plt_pkg.sv]
// Constants and types shared by the loopback and test-mode block.
package plt_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] PLT_OFS_CTRL    = 4'h0;
  localparam logic [3:0] PLT_OFS_STATUS  = 4'h4;
  localparam logic [3:0] PLT_OFS_SETTING = 4'h8;
  // Control register: field position and value after reset
  localparam int         PLT_CTRL_RESYNC_BIT = 0;
  localparam logic       PLT_CTRL_RESET      = 1'b0;
  // Status register field positions
  localparam int PLT_ST_TEST_BIT   = 0;
  localparam int PLT_ST_DISC_BIT   = 1;
  localparam int PLT_ST_DIR_BIT    = 2;
  localparam int PLT_ST_SWITCH_BIT = 3;
  localparam int PLT_ST_OE_LSB     = 4;
  localparam int PLT_ST_MULT_LSB   = 8;
  localparam int PLT_ST_STATE_LSB  = 12;
  // Decoded control codes of the test entry symbol
  localparam logic [7:0] PLT_COMMA_BYTE = 8'hBC;
  localparam logic [7:0] PLT_ENTRY_KCODE = 8'hFE;
  // Repetitions of the entry symbol needed before it counts
  localparam logic [2:0] PLT_ENTRY_REPEAT = 3'h4;
  // Main mode codes in the upper nibble of the primary setting
  localparam logic [3:0] PLT_MAIN_LOOPBACK = 4'h0;
  localparam logic [3:0] PLT_MAIN_VENDOR   = 4'hF;
  // Sub mode bits of the primary setting
  localparam int PLT_SUB_TIMING_BIT = 0;
  localparam int PLT_SUB_DISC_BIT   = 1;
  // Fields of the secondary setting
  localparam int PLT_SEC_DIR_BIT  = 7;
  localparam int PLT_SEC_MULT_MSB = 2;
  localparam logic [2:0] PLT_MULT_X15 = 3'h0;
  localparam logic [2:0] PLT_MULT_X30 = 3'h1;
  // Reset values of settings and lanes
  localparam logic [7:0] PLT_SETTING_RESET = 8'h00;
  localparam logic [9:0] PLT_SYM_RESET     = 10'h000;
  // Lane indices
  localparam int PLT_LANE_H2D = 0;
  localparam int PLT_LANE_D2H = 1;
  // Power state machine, one-hot
  typedef enum logic [3:0] {
    PLT_PS_ACTIVE  = 4'b0001,
    PLT_PS_DORMANT = 4'b0010,
    PLT_PS_RESYNC  = 4'b0100,
    PLT_PS_EXIT    = 4'b1000
  } plt_pstate_t;
endpackage

// [bench/plt_loopback_props.sv]
// Port-level checker for the loopback and test-mode block.
`timescale 1ns/1ns
`default_nettype none
module plt_loopback_props (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       avs_read_in,
  input wire logic       avs_write_in,
  input wire logic       avs_waitrequest_out,
  input wire logic       h2d_tx_oe_out,
  input wire logic       d2h_tx_oe_out,
  input wire logic       phy_power_en_out,
  input wire logic       amp_det_en_out,
  input wire logic       pll_run_out,
  input wire logic [2:0] pll_mult_out,
  input wire logic       cdr_resync_out,
  input wire logic       test_mode_out
);
  // One clock domain, so clock and reset are stated once
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_AMP_ON: assert property (amp_det_en_out) else $error("detector unpowered");
  AST_OE_ONE: assert property (!(h2d_tx_oe_out && d2h_tx_oe_out)) else $error("both lanes out");
  AST_PULSE: assert property (cdr_resync_out |=> !cdr_resync_out) else $error("resync too long");
  AST_WAKE: assert property ($rose(phy_power_en_out) |-> cdr_resync_out) else $error("no resync");
  AST_DORM_PLL: assert property (!phy_power_en_out |-> !pll_run_out) else $error("pll on");
  AST_MULT: assert property ($changed(pll_mult_out)
    |-> cdr_resync_out || $past(cdr_resync_out)) else $error("multiplier changed outside exit");
  AST_FLOAT: assert property ($fell(h2d_tx_oe_out) || $fell(d2h_tx_oe_out)
    |-> !(h2d_tx_oe_out || d2h_tx_oe_out)) else $error("lane driven across switch");
  AST_TEST_HOLD: assert property (test_mode_out |=> test_mode_out) else $error("test left");
  // At most one wait state, and no stall while idle
  AST_ONE_WAIT: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("wait state count");
  AST_IDLE: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("stall while idle");
endmodule
bind plt_loopback plt_loopback_props u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .h2d_tx_oe_out(h2d_tx_oe_out),
  .d2h_tx_oe_out(d2h_tx_oe_out), .phy_power_en_out(phy_power_en_out),
  .amp_det_en_out(amp_det_en_out), .pll_run_out(pll_run_out), .pll_mult_out(pll_mult_out),
  .cdr_resync_out(cdr_resync_out), .test_mode_out(test_mode_out));
`default_nettype wire

// [bench/plt_link_model.sv]
// Host-side partner: recovered symbol clock and both deserializer lanes.
`timescale 1ns/1ns
`default_nettype none
module plt_link_model (
  output logic       sclk_out,
  output logic [9:0] h_sym_out,
  output logic [9:0] d_sym_out,
  output logic [7:0] h_byte_out,
  output logic [7:0] d_byte_out,
  output logic       h_k_out,
  output logic       d_k_out
);
  // Clock stands low between symbols
  initial sclk_out = 1'b0;
  // Lane 0 is host_to_device, 1 device_to_host; silent lane shows the inverse
  task automatic put(input bit ln, input logic [18:0] v);
    if (ln) begin
      {d_sym_out, d_byte_out, d_k_out} = v;
      {h_sym_out, h_byte_out, h_k_out} = ~v;
    end else begin
      {h_sym_out, h_byte_out, h_k_out} = v;
      {d_sym_out, d_byte_out, d_k_out} = ~v;
    end
    // Data moves only while the clock is low, so the sampler never races
    #40 sclk_out = 1'b1;
    #40 sclk_out = 1'b0;
  endtask
  // Host loopback: forward answers on lane 0 what it heard on lane 1,
  // backward answers on lane 1 what it heard on lane 0
  task automatic echo(input bit bwd, input logic [9:0] s);
    put(bwd, {s, 8'h00, 1'b0});
  endtask
endmodule
`default_nettype wire

// [bench/tb_plt_loopback.sv]
// Self-checking bench for the loopback and test-mode block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_plt_loopback;
  import plt_pkg::*;
  localparam logic [18:0] SYNC = {10'h2AA, 8'h00, 1'b1}; // Sync symbol, K code 00
  logic        clk_in, rst_n_in, rd, wr, lp, amp, le;   // Bench-driven inputs
  logic [3:0]  adr;                                     // Bus address
  logic [31:0] wd, q, rdat;                             // Write data, read copy, read bus
  logic [9:0]  hs, ds, hts, dts;                        // Lane symbols in and out
  logic [7:0]  hb, db;                                  // Decoded bytes
  logic [2:0]  mul;                                     // Active multiplier
  logic        hk, dk, sck, wq, hoe, doe, pwr, tm;      // Flags
  int          err_total, checks_done, cyc;             // Counters
  plt_loopback dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .sym_clk_in(sck),
    .h2d_rx_sym_in(hs), .h2d_rx_byte_in(hb), .h2d_rx_k_in(hk), .d2h_rx_sym_in(ds),
    .d2h_rx_byte_in(db), .d2h_rx_k_in(dk), .amp_det_in(amp),
    .h2d_tx_link_sym_in(10'h000), .d2h_tx_link_sym_in(10'h000), .ll_loop_en_in(le),
    .ll_loop_back_in(1'b0), .lp_req_in(lp), .h2d_tx_sym_out(hts), .d2h_tx_sym_out(dts),
    .h2d_tx_oe_out(hoe), .d2h_tx_oe_out(doe), .phy_power_en_out(pwr),
    .amp_det_en_out(), .pll_run_out(), .pll_mult_out(mul), .cdr_resync_out(),
    .test_mode_out(tm));
  plt_link_model lm (.sclk_out(sck), .h_sym_out(hs), .d_sym_out(ds), .h_byte_out(hb),
    .d_byte_out(db), .h_k_out(hk), .d_k_out(dk));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Request held until waitrequest is seen low; read data taken there
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {adr, wd, wr, rd} <= {a, d, w, !w};
    do @(posedge clk_in); while (wq);
    q = rdat;
    {wr, rd} <= 2'b00;
  endtask
  // One symbol, then time for the capture and the output register
  task automatic send(input bit ln, input logic [18:0] v);
    lm.put(ln, v);
    repeat (6) @(posedge clk_in);
  endtask
  task automatic entry(input bit ln, input logic [7:0] p, s, input int n);
    repeat (n) begin
      lm.put(ln, {10'h17C, PLT_COMMA_BYTE, 1'b1});
      lm.put(ln, {10'h17E, PLT_ENTRY_KCODE, 1'b1});
      lm.put(ln, {2'b01, p, p, 1'b0});
      send(ln, {2'b10, s, s, 1'b0});
    end
  endtask
  // Low-power request as a single-cycle level
  task automatic lpr;
    @(posedge clk_in) lp <= 1'b1;
    @(posedge clk_in) lp <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic wake;
    @(posedge clk_in) amp <= 1'b1;
    repeat (6) @(posedge clk_in);
    amp <= 1'b0;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, far above the roughly 1250 cycles the run needs
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out;
    end
  end
  initial begin
    {rd, wr, lp, amp, adr, wd, rst_n_in, le} = '0;
    le = 1'b1;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    `CHK({tm, hoe, doe, mul}, 6'h08)
    bus(0, PLT_OFS_CTRL, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    bus(1, PLT_OFS_STATUS, 32'hFFFF_FFFF);
    bus(0, PLT_OFS_STATUS, 32'h0000_0000);
    `CHK(q[15:12], 4'h1)
    bus(0, 4'hC, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    // Link-layer loop carries an illegal code group untouched
    send(0, {10'h3FF, 8'h00, 1'b0});
    `CHK(dts, 10'h3FF)
    entry(0, 8'h00, 8'h01, 3);
    send(0, {10'h155, 8'h55, 1'b0});
    `CHK(tm, 1'b0)
    entry(0, 8'h00, 8'h01, 4);
    `CHK({tm, mul}, {1'b1, PLT_MULT_X15})
    le <= 1'b0;
    send(0, {10'h2C3, 8'h00, 1'b0});
    `CHK(dts, 10'h2C3)
    lm.echo(0, dts);
    repeat (6) @(posedge clk_in);
    `CHK(dts, 10'h2C3)
    lpr;
    `CHK(pwr, 1'b0)
    wake;
    `CHK({pwr, mul}, {1'b1, PLT_MULT_X30})
    entry(0, 8'h00, 8'h81, 4);
    `CHK({hoe, doe}, 2'b00)
    send(1, SYNC);
    send(1, {10'h0F0, 8'h00, 1'b0});
    `CHK({hoe, doe, hts}, {2'b10, 10'h0F0})
    lm.echo(1, hts);
    repeat (6) @(posedge clk_in);
    `CHK(hts, 10'h0F0)
    bus(1, PLT_OFS_CTRL, 32'h0000_0001);
    lpr;
    bus(0, PLT_OFS_STATUS, 32'h0000_0000);
    `CHK({pwr, q[15:12]}, {1'b1, 4'h4})
    send(1, SYNC);
    bus(0, PLT_OFS_STATUS, 32'h0000_0000);
    `CHK(q[15:12], 4'h1)
    entry(1, 8'h00, 8'h01, 4);
    send(0, SYNC);
    `CHK({hoe, doe}, 2'b01)
    entry(0, 8'h02, 8'h01, 4);
    lpr;
    `CHK(pwr, 1'b1)
    entry(0, 8'h00, 8'h01, 4);
    lpr;
    `CHK(pwr, 1'b0)
    wake;
    // Deferred disconnect only lands on the next low-power exit, here from Dormant
    entry(0, 8'h03, 8'h01, 4);
    bus(0, PLT_OFS_STATUS, 32'h0000_0000);
    `CHK(q[PLT_ST_DISC_BIT], 1'b0)
    lpr;
    `CHK(pwr, 1'b0)
    wake;
    bus(0, PLT_OFS_STATUS, 32'h0000_0000);
    `CHK(q[PLT_ST_DISC_BIT], 1'b1)
    close_out;
  end
endmodule
`default_nettype wire
